//--- rcfg_fanout.sv
// Top of the fan-out buffer: power-up sequencer, enable synchronisers, outputs
`timescale 1ns/1ps
module rcfg_fanout
    import rcfg_pkg::*;
#(
    parameter int PWR_DELAY_CYC = RCFG_PWR_DELAY_CYC
)(
    input wire logic clk,                                   // Reference clock input
    input wire logic srst,                                  // Power-on reset, active high
    input wire logic supply_ok,                             // Supply present, async level
    input wire logic ref_clk_ok,                            // Reference clock valid, async
    input wire logic out_enable_first_n,                    // Enable output 0, active low
    input wire logic out_enable_second_n,                   // Enable output 1, active low
    output logic [rcfg_pkg::RCFG_OUTPUTS-1:0] fanout_clk_out, // Gated clock outputs
    output logic [rcfg_pkg::RCFG_OUTPUTS-1:0] fanout_oe,      // High while output driven
    output logic operating                                  // Sequencer in operating state
);
    import rcfg_pkg::*;

    localparam int CW = $clog2(PWR_DELAY_CYC + 1);
    localparam logic [CW-1:0] DELAY_LAST = CW'(PWR_DELAY_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    rcfg_gate_if #(.N(RCFG_OUTPUTS)) gif ();

    rcfg_state_t state;
    rcfg_state_t next_state;
    logic [CW-1:0] delay_cnt;
    logic [CW-1:0] next_delay_cnt;

    // Two-stage synchronisers; stage one feeds stage two only
    logic supply_meta;
    logic supply_s;
    logic ref_meta;
    logic ref_s;
    logic [RCFG_OUTPUTS-1:0] en_n_raw;
    logic [RCFG_OUTPUTS-1:0] en_n_meta;
    logic [RCFG_OUTPUTS-1:0] en_n_s;

    assign en_n_raw = {out_enable_second_n, out_enable_first_n};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            supply_meta <= RCFG_SYNC_RESET_LOW;
            supply_s <= RCFG_SYNC_RESET_LOW;
            ref_meta <= RCFG_SYNC_RESET_LOW;
            ref_s <= RCFG_SYNC_RESET_LOW;
            en_n_meta <= {RCFG_OUTPUTS{RCFG_ENABLE_N_IDLE}};
            en_n_s <= {RCFG_OUTPUTS{RCFG_ENABLE_N_IDLE}};
        end
        else
        begin
            supply_meta <= supply_ok;
            supply_s <= supply_meta;
            ref_meta <= ref_clk_ok;
            ref_s <= ref_meta;
            en_n_meta <= en_n_raw; // RULE_03
            en_n_s <= en_n_meta; // RULE_03
        end
    end

    wire delay_done = (delay_cnt == DELAY_LAST);

    // Loss of supply drops back to power-off from any state
    always_comb
    begin
        next_state = state;
        unique case (state)
            st_power_off:
                if (supply_s)
                    next_state = st_power_delay; // RULE_08
            st_power_delay:
                if (!supply_s)
                    next_state = st_power_off;
                else if (delay_done)
                    next_state = st_wait_ref; // RULE_08
            st_wait_ref:
                if (!supply_s)
                    next_state = st_power_off;
                else if (ref_s)
                    next_state = st_operating; // RULE_09 RULE_10
            st_operating:
                if (!supply_s)
                    next_state = st_power_off;
        endcase
    end

    assign next_delay_cnt = (state == st_power_delay && !delay_done)
                            ? delay_cnt + CNT_ONE : CNT_ZERO;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= st_power_off;
            delay_cnt <= CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            delay_cnt <= next_delay_cnt; // RULE_08
        end
    end

    // Requests are held off entirely until the operating state
    assign gif.ready = (state == st_operating); // RULE_11 RULE_10
    assign gif.want = ~en_n_s; // RULE_01 RULE_02

    rcfg_out_gate u_gate (
        .clk (clk),
        .srst (srst),
        .gif (gif.gate)
    );

    // Gate only changes while clk is low, so the AND yields whole pulses
    assign fanout_clk_out = gif.gate_on & {RCFG_OUTPUTS{clk}}; // RULE_12
    assign fanout_oe = gif.gate_on; // RULE_01
    assign operating = gif.ready;

    a_off_tristate: assert property ( // RULE_11
        @(posedge clk) disable iff (srst)
        (state != st_operating) ##1 (state != st_operating) |-> fanout_oe == '0)
        else $error("Output driven before operating state");

    a_power_leave_off: assert property ( // RULE_08
        @(posedge clk) disable iff (srst)
        (state == st_power_off && supply_s) |=> state == st_power_delay)
        else $error("Supply detected but delay not entered");

    a_delay_length: assert property ( // RULE_08
        @(posedge clk) disable iff (srst)
        (state == st_power_delay && $past(state) == st_power_delay
            && $past(state, 2) != st_power_delay && supply_s)
        |-> ##(2) 1'b1 ##0 (delay_cnt != CNT_ZERO || state != st_power_delay))
        else $error("Delay counter did not advance");

    a_delay_exit: assert property ( // RULE_08
        @(posedge clk) disable iff (srst)
        (state == st_power_delay && $past(state) == st_power_delay && next_state == st_wait_ref)
        |-> delay_cnt == DELAY_LAST)
        else $error("Delay left before its full length");

    a_wait_for_ref: assert property ( // RULE_09
        @(posedge clk) disable iff (srst)
        (state == st_wait_ref && !ref_s && supply_s) |=> state == st_wait_ref)
        else $error("Left waiting state without a valid reference");

    a_enter_operating: assert property ( // RULE_10
        @(posedge clk) disable iff (srst)
        (state == st_wait_ref && ref_s && supply_s) |=> operating)
        else $error("Valid reference did not reach operating state");

    generate
        for (genvar g = 0; g < RCFG_OUTPUTS; g++)
        begin : g_chk
            a_enable_latency: assert property ( // RULE_05
                @(posedge clk) disable iff (srst)
                (operating && $fell(en_n_raw[g])) ##1 (operating && !en_n_raw[g]) [*2]
                |-> fanout_oe[g])
                else $error("Output not enabled within the allowed latency");
            a_disable_latency: assert property ( // RULE_07
                @(posedge clk) disable iff (srst)
                $rose(en_n_raw[g]) ##1 en_n_raw[g] [*2] |-> !fanout_oe[g])
                else $error("Output not tri-stated within the allowed latency");
            a_outputs_indep: assert property ( // RULE_02
                @(posedge clk) disable iff (srst)
                ($changed(fanout_oe[g]) && $stable(state)) |-> $changed(gif.want[g]))
                else $error("Output changed without its own enable changing");
        end
    endgenerate
endmodule

//--- rcfg_gate_if.sv
// Request and gate state passed between the sequencer and the output gates
`timescale 1ns/1ps
interface rcfg_gate_if
    import rcfg_pkg::*;
#(
    parameter int N = RCFG_OUTPUTS
);
    logic [N-1:0] want;
    logic ready;
    logic [N-1:0] gate_on;

    modport seq (output want, output ready, input gate_on);
    modport gate (input want, input ready, output gate_on);
endinterface

//--- rcfg_out_gate.sv
// Low-phase output gate for all fan-out outputs
`timescale 1ns/1ps
module rcfg_out_gate
    import rcfg_pkg::*;
(
    input wire logic clk,         // Reference clock
    input wire logic srst,        // Synchronous reset, active high
    rcfg_gate_if.gate gif         // Requests in, gate state out
);
    logic [$bits(gif.want)-1:0] next_gate;

    assign next_gate = gif.want & {$bits(gif.want){gif.ready}};

    // Falling edge update: the clock is low, so no pulse is cut short
    always_ff @(negedge clk)
    begin
        if (srst)
            gif.gate_on <= {$bits(gif.want){RCFG_GATE_RESET}};
        else
            gif.gate_on <= next_gate; // RULE_12 RULE_04 RULE_06
    end

    generate
        for (genvar g = 0; g < $bits(gif.want); g++)
        begin : g_chk
            a_rise_needs_want: assert property ( // RULE_04
                @(posedge clk) disable iff (srst)
                $rose(gif.gate_on[g]) |-> gif.want[g] && gif.ready)
                else $error("Gate opened without a request");
            a_fall_needs_drop: assert property ( // RULE_06
                @(posedge clk) disable iff (srst)
                $fell(gif.gate_on[g]) |-> !(gif.want[g] && gif.ready))
                else $error("Gate closed while still requested");
        end
    endgenerate
endmodule

//--- rcfg_pkg.sv
// Constants and types for the two-output reference clock fan-out gating block
// What this block does
// RULE_01: Enable pins are active low; 0 drives the output, 1 tri-states it.
// RULE_02: Each of the two outputs has its own enable, switched independently.
// RULE_03: Enables may change any time; they are synchronised before use.
// RULE_04: A tri-stated output resumes driving without a runt pulse.
// RULE_05: Enable assertion to output toggling takes two to six clock periods.
// RULE_06: An output stops driving without a runt pulse before tri-state.
// RULE_07: Enable deassertion to tri-state takes two to six clock periods.
// RULE_08: On supply detection, leave power-off and wait 0.2 to 0.3 ms.
// RULE_09: After the delay, wait until a valid reference clock is present.
// RULE_10: With a valid reference clock, enter operating state and enable outputs.
// RULE_11: Both outputs stay tri-stated until the operating state is reached.
// RULE_12: Gating changes only in the reference clock low phase, keeping full pulses.
package rcfg_pkg;

    localparam int RCFG_OUTPUTS = 2;
    localparam int RCFG_CLK_PERIOD_NS = 10;
    // Least power-up delay, in microseconds
    localparam int RCFG_PWR_DELAY_US = 200;
    localparam int RCFG_NS_PER_US = 1000;
    // Least time rounds up to whole cycles
    localparam int RCFG_PWR_DELAY_CYC =
        (RCFG_PWR_DELAY_US * RCFG_NS_PER_US + RCFG_CLK_PERIOD_NS - 1) / RCFG_CLK_PERIOD_NS;

    // Idle level of a synchronised active-low enable
    localparam logic RCFG_ENABLE_N_IDLE = 1'b1;
    localparam logic RCFG_GATE_RESET = 1'b0;
    localparam logic RCFG_SYNC_RESET_LOW = 1'b0;

    typedef enum logic [1:0] {
        st_power_off,
        st_power_delay,
        st_wait_ref,
        st_operating
    } rcfg_state_t;

endpackage

//--- rcfg_sys_model.sv
// System logic model that drives the two active-low output enables
`timescale 1ns/1ps
module rcfg_sys_model (
    input wire logic clk,               // Reference clock
    input wire logic [1:0] want,        // Requested enables, active high
    input wire logic slow,              // Hold pins one extra cycle
    output logic out_enable_first_n,    // Enable of output 0, active low
    output logic out_enable_second_n    // Enable of output 1, active low
);
    logic [1:0] held;
    initial
    begin
        held = 2'b00;
        out_enable_first_n = 1'b1;
        out_enable_second_n = 1'b1;
    end
    // Pins move only on the falling edge, as real system logic would
    always @(negedge clk)
    begin
        held <= want;
        out_enable_first_n <= ~(slow ? held[0] : want[0]);
        out_enable_second_n <= ~(slow ? held[1] : want[1]);
    end
endmodule

//--- testbench.sv
// Self-checking bench for the reference clock fan-out block
`timescale 1ns/1ps
module testbench;
    import rcfg_pkg::*;
    localparam int PWR = 8;
    logic clk, srst, supply_ok, ref_clk_ok, slow, en0_n, en1_n, operating, prev_op;
    logic [1:0] want, fanout_clk_out, fanout_oe, prev_oe, mid_oe;
    int err_count, num_checks, cyc, seed, i, b, d;
    logic [1:0] exp_q[$];
    time time_q[$];
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    rcfg_sys_model sys (.clk(clk), .want(want), .slow(slow),
        .out_enable_first_n(en0_n), .out_enable_second_n(en1_n));
    rcfg_fanout #(.PWR_DELAY_CYC(PWR)) uut (.clk(clk), .srst(srst), .supply_ok(supply_ok),
        .ref_clk_ok(ref_clk_ok), .out_enable_first_n(en0_n), .out_enable_second_n(en1_n),
        .fanout_clk_out(fanout_clk_out), .fanout_oe(fanout_oe), .operating(operating));
    function automatic bit pass(input bit ok);
        num_checks++;
        return ok;
    endfunction
    task automatic fail(input string msg);
        err_count++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Note the expected drive state; 0 time means no latency bound applies
    task automatic expect_oe(input logic [1:0] v, input time t);
        exp_q.push_back(v);
        time_q.push_back(t);
    endtask
    task automatic wait_op(input int lo, input int hi);
        int n;
        n = 0;
        while (operating !== 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        if (!pass(n >= lo && n <= hi)) fail("operating entry time");
    endtask
    // Observer: outputs sampled just after each rising edge
    initial
    begin
        prev_oe = 2'b00;
        prev_op = 1'b0;
        forever
        begin
            @(posedge clk);
            #1;
            cyc++;
            if (cyc > 3000)
            begin
                fail("timeout");
                give_verdict();
            end
            // Gate flops settle on the first falling edge of reset
            if (srst)
                continue;
            if (!prev_op && !pass(fanout_oe === 2'b00)) fail("driven outside operating");
            if (!pass(fanout_clk_out === fanout_oe)) fail("high phase not full");
            if (fanout_oe !== prev_oe)
            begin
                if (exp_q.size() == 0)
                    fail("unexpected drive change");
                else
                begin
                    d = $time - time_q[0] - 5;
                    if (!pass(fanout_oe === exp_q.pop_front())) fail("drive state");
                    if (time_q[0] != 0 && !pass(d >= 20 && d <= 66)) fail("latency");
                    void'(time_q.pop_front());
                end
            end
            prev_oe = fanout_oe;
            prev_op = operating;
            mid_oe = fanout_oe;
            #3;
            if (!pass(fanout_oe === mid_oe)) fail("gate moved in high phase");
        end
    end
    always @(negedge clk)
    begin
        #1;
        if (!pass(fanout_clk_out === 2'b00)) fail("output high in low phase");
    end
    initial
    begin
        seed = 32'habe5;
        srst = 1'b1;
        supply_ok = 1'b0;
        ref_clk_ok = 1'b0;
        slow = 1'b0;
        want = 2'b11;
        err_count = 0;
        num_checks = 0;
        cyc = 0;
        expect_oe(2'b11, 0);
        repeat (5) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        repeat (6) @(negedge clk);
        supply_ok = 1'b1;
        repeat (PWR + 8) @(negedge clk);
        if (!pass(operating === 1'b0)) fail("operating without reference");
        ref_clk_ok = 1'b1;
        wait_op(1, 5);
        for (i = 0; i < 30; i++)
        begin
            b = $random(seed) & 1;
            slow = $random(seed) & 1;
            @(posedge clk);
            want[b] <= ~want[b];
            expect_oe(want ^ (2'b01 << b), $time + (slow ? 10 : 0));
            repeat (8 + ($random(seed) & 3)) @(negedge clk);
        end
        // Supply loss drops everything; a second power-up times the delay
        if (want != 2'b11)
            expect_oe(2'b11, 0);
        want = 2'b11;
        slow = 1'b0;
        repeat (8) @(negedge clk);
        supply_ok = 1'b0;
        expect_oe(2'b00, 0);
        repeat (8) @(negedge clk);
        if (!pass(operating === 1'b0)) fail("operating after supply loss");
        supply_ok = 1'b1;
        expect_oe(2'b11, 0);
        wait_op(PWR + 2, PWR + 8);
        repeat (8) @(negedge clk);
        if (!pass(exp_q.size() == 0)) fail("missing drive change");
        give_verdict();
    end
endmodule
